// File: lfp_pkg.sv
// Constants, register map and carrier types for the table-driven fan PWM block.
// Assumes a 10 MHz system clock and an 8-bit internal register port.
// Functional notes
// [R1] Duty is PWM value over full-duty value for the selected frequency.
// [R2] Twelve-entry table pairs a temperature setpoint with a duty value.
// [R3] At 22.5 kHz a high-resolution mode gives 255 duty steps; code has HR_DIV of 1, a 255-clock period near 39.2 kHz.
// [R4] Without smoothing, duty jumps to the new entry at once.
// [R5] With smoothing, duty climbs one LSB per programmed interval.
// [R6] Below the lowest setpoint the duty is zero.
// [R7] Between two setpoints the lower entry's duty holds.
// [R8] Setpoint comparison resolution is selectable, one or half degree.
// [R9] In half-degree mode a transition starts half a degree above setpoint.
// [R10] Falling temperature compares against setpoints lowered by the hysteresis.
// [R11] Critical temperature forces full duty at once, bypassing table and ramp.
// [R12] Smoothing interval selects 0.182, 0.091, 0.046 or 0.023 s per step; code gives 0.184, 0.092, 0.046 or 0.023 s.
// [R13] One smoothing interval applies to every table transition.
// [R14] Tach count counts 90 kHz clock periods against the fan tach input.
// [R15] Count spans two tach pulses, one revolution of a two-pulse fan.
// [R16] Count is read as low byte at 0x46 and high byte at 0x47.
// [R17] Host computes RPM as factor times 5,400,000 over the count.
// [R18] Host should program setpoints and duties ascending with index.
// [R19] Host sets high-res enable, clears clock select, writes frequency 0x08.
// [R20] Critical output asserts while remote temperature exceeds the limit.
// [R21] With smoothing, falling duty also steps down one LSB per interval.
package lfp_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int TACH_HZ = 90_000;
  localparam int TACH_DIV = (CLK_HZ / TACH_HZ < 1) ? 1 : CLK_HZ / TACH_HZ;
  localparam int PCLK_HI_HZ = 360_000;
  localparam int PCLK_HI_DIV = (CLK_HZ / PCLK_HI_HZ < 1) ? 1 : CLK_HZ / PCLK_HI_HZ;
  localparam int PCLK_LO_HZ = 1_400;
  localparam int HR_PWM_HZ = 22_500;
  localparam int HR_STEPS = 255;
  localparam int HR_DIV = (CLK_HZ / (HR_PWM_HZ * HR_STEPS) < 1) ? 1 :
    CLK_HZ / (HR_PWM_HZ * HR_STEPS);
  localparam int SMOOTH_BASE_US = 23_000;
  localparam int N_LUT = 12;
  localparam int DUTY_W = 8;
  localparam int TEMP_W = 11;
  localparam int DIV_W = 16;
  localparam int SM_W = 22;
  localparam logic [7:0] HR_FULL = 8'hFF;
  localparam logic [7:0] A_ENH_CFG = 8'h45;
  localparam logic [7:0] A_TACH_LO = 8'h46;
  localparam logic [7:0] A_TACH_HI = 8'h47;
  localparam logic [7:0] A_PWM_CFG = 8'h4A;
  localparam logic [7:0] A_PWM_VAL = 8'h4C;
  localparam logic [7:0] A_PWM_FREQ = 8'h4D;
  localparam logic [7:0] A_HYST = 8'h4E;
  localparam logic [7:0] A_SMOOTH = 8'h4F;
  localparam logic [7:0] A_CRIT = 8'h19;
  localparam logic [7:0] A_LUT_BASE = 8'h50;
  localparam logic [7:0] A_LUT_LAST = 8'h67;
  localparam int B_HIRES = 4;
  localparam int B_CLKSEL = 3;
  localparam int B_SM_EN = 5;
  localparam int B_HALF = 0;
  localparam logic [4:0] RST_FREQ = 5'h08;
  localparam logic [7:0] RST_HYST = 8'h04;
  localparam logic [7:0] RST_CRIT = 8'h55;
  localparam logic [7:0] RST_LUT_T = 8'hFF;
  localparam logic [7:0] RST_LUT_D = 8'h00;

  typedef struct packed {
    logic hires;
    logic clk_sel;
    logic [4:0] freq;
  } lfp_pwm_cfg_s;

  typedef enum logic [1:0] {
    RAMP_HOLD = 2'b00,
    RAMP_UP = 2'b01,
    RAMP_DOWN = 2'b11
  } lfp_ramp_e;

  // Frequency code 0 behaves as code 1
  function automatic logic [7:0] full_duty(input lfp_pwm_cfg_s cfg);
    if (cfg.hires) begin
      full_duty = HR_FULL; // [R3]
    end else if (cfg.freq == 5'h00) begin
      full_duty = 8'h02;
    end else begin
      full_duty = {2'b00, cfg.freq, 1'b0}; // [R1]
    end
  endfunction : full_duty
endpackage : lfp_pkg

// File: lfp_pwm_gen.sv
// PWM counter and open-drain fan drive.
// Assumes duty and configuration are stable flip-flop outputs of the controller.
`timescale 1ns/1ns
`default_nettype none
module lfp_pwm_gen #(
  parameter int LO_DIV = 7142
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire lfp_pkg::lfp_pwm_cfg_s cfg_i,
  input wire logic [lfp_pkg::DUTY_W-1:0] duty_i,
  // Fan pin
  output logic pwm_o,
  output logic pwm_pin_o,
  output logic pwm_pin_oe_o
);
  import lfp_pkg::*;

  logic [DIV_W-1:0] div_cnt;
  logic [7:0] per_cnt;
  wire [DIV_W-1:0] div_end = cfg_i.hires ? DIV_W'(HR_DIV - 1) :
    cfg_i.clk_sel ? DIV_W'(LO_DIV - 1) : DIV_W'(PCLK_HI_DIV - 1);
  wire tick = (div_cnt >= div_end);
  wire [7:0] full = full_duty(cfg_i);
  wire per_end = (per_cnt >= full - 8'h01);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= tick ? '0 : div_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      per_cnt <= '0;
      pwm_o <= 1'b0;
    end else if (tick) begin
      per_cnt <= per_end ? 8'h00 : per_cnt + 8'h01;
      pwm_o <= (per_cnt < duty_i); // [R1]
    end
  end

  // Open drain: pull low while off, released while on
  assign pwm_pin_o = 1'b0;
  assign pwm_pin_oe_o = ~pwm_o;
endmodule : lfp_pwm_gen
`default_nettype wire

// File: lfp_tach_count.sv
// Fan tach period counter on the 90 kHz enable.
// Assumes tach_i is a clean level from the fan, synchronised here.
`timescale 1ns/1ns
`default_nettype none
module lfp_tach_count #(
  parameter int DIV = 111
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fan tach
  input wire logic tach_i,
  // Result
  output logic [15:0] count_o
);
  import lfp_pkg::*;

  logic s1, s2, s3;
  logic [DIV_W-1:0] div_cnt;
  logic [15:0] run;
  logic second;
  wire tick = (div_cnt >= DIV_W'(DIV - 1));
  wire rise = s2 & ~s3;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Idle tach level is high, so no false edge after reset
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      div_cnt <= '0;
    end else begin
      s1 <= tach_i;
      s2 <= s1;
      s3 <= s2;
      div_cnt <= tick ? '0 : div_cnt + 1'b1; // [R14]
    end
  end

  // Saturate the running count; count_o loads only on every second tach rise, so a stalled fan keeps its last reading
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run <= '0;
      second <= 1'b0;
      count_o <= 16'hFFFF;
    end else if (rise) begin
      second <= ~second;
      if (second) begin
        count_o <= run; // [R15]
        run <= '0;
      end
    end else if (tick && run != 16'hFFFF) begin
      run <= run + 16'h0001; // [R14]
    end
  end
endmodule : lfp_tach_count
`default_nettype wire

// File: lfp_fan_ctrl.sv
// Table-driven fan controller: registers, table lookup, ramp, critical force.
// Assumes an internal register port from the serial interface engine and a
// remote temperature in 1/8 degree steps from the conversion logic.
`timescale 1ns/1ns
`default_nettype none
module lfp_fan_ctrl #(
  parameter int PWM_LO_DIV = lfp_pkg::CLK_HZ / lfp_pkg::PCLK_LO_HZ,
  parameter int SMOOTH_BASE_CYC = lfp_pkg::SMOOTH_BASE_US * (lfp_pkg::CLK_HZ / 1_000_000),
  parameter int N_ENTRIES = lfp_pkg::N_LUT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Temperature
  input wire logic [lfp_pkg::TEMP_W-1:0] remote_temp_i,
  // Fan pins
  input wire logic tach_i,
  output logic pwm_o,
  output logic pwm_pin_o,
  output logic pwm_pin_oe_o,
  // Critical temperature pin
  output logic critical_temp_output_o,
  output logic crit_pin_o,
  output logic crit_pin_oe_o
);
  import lfp_pkg::*;

  // Compare in half-degree units, threshold lowered by hyst
  function automatic logic above(input logic [8:0] t, input logic [7:0] sp,
                                 input logic [7:0] hyst, input logic half);
    logic [9:0] thr;
    logic [9:0] lim;
    thr = {2'b00, sp} - {2'b00, hyst}; // [R10]
    lim = {thr[8:0], 1'b0} + (half ? 10'h001 : 10'h002); // [R8] [R9]
    above = thr[9] | ({1'b0, t} >= lim);
  endfunction : above

  lfp_pwm_cfg_s cfg;
  logic [7:0] hyst;
  logic [7:0] crit_lim;
  logic smooth_en;
  logic half_res;
  logic [1:0] sm_sel;
  logic [7:0] lut_t [N_ENTRIES];
  logic [7:0] lut_d [N_ENTRIES];
  logic [3:0] idx;
  logic [7:0] cur;
  logic [7:0] out_duty;
  logic crit;
  logic [SM_W-1:0] sm_cnt;
  lfp_ramp_e state;
  lfp_ramp_e next_state;
  logic [3:0] up_cnt;
  logic [3:0] hold_cnt;
  logic [3:0] next_idx;
  logic [7:0] next_cur;
  logic [7:0] next_rdata;
  logic [15:0] tach_cnt;

  // Register decode
  wire [7:0] lut_off = reg_addr_i - A_LUT_BASE;
  wire lut_hit = (reg_addr_i >= A_LUT_BASE) && (reg_addr_i <= A_LUT_LAST);
  wire [3:0] lut_idx = lut_off[4:1];
  wire [8:0] t_half = remote_temp_i[TEMP_W-1:2];
  wire [7:0] t_int = remote_temp_i[TEMP_W-1:3];
  wire [7:0] full = full_duty(cfg);
  wire [SM_W-1:0] sm_end = (SM_W'(SMOOTH_BASE_CYC) << (2'd3 - sm_sel)) - SM_W'(1); // [R12] [R13]
  wire sm_step = (sm_cnt >= sm_end);
  wire [7:0] target = (idx == 4'h0) ? 8'h00 : lut_d[idx - 4'h1]; // [R6] [R7]

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg <= '{hires: 1'b0, clk_sel: 1'b0, freq: RST_FREQ};
      hyst <= RST_HYST;
      crit_lim <= RST_CRIT;
      smooth_en <= 1'b0;
      half_res <= 1'b0;
      sm_sel <= 2'b00;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        A_ENH_CFG: cfg.hires <= reg_wdata_i[B_HIRES]; // [R3]
        A_PWM_CFG: cfg.clk_sel <= reg_wdata_i[B_CLKSEL];
        A_PWM_FREQ: cfg.freq <= reg_wdata_i[4:0];
        A_HYST: hyst <= reg_wdata_i;
        A_CRIT: crit_lim <= reg_wdata_i;
        A_SMOOTH: begin
          smooth_en <= reg_wdata_i[B_SM_EN];
          sm_sel <= reg_wdata_i[2:1];
          half_res <= reg_wdata_i[B_HALF];
        end
        default: begin
        end
      endcase
    end
  end

  // Table storage, even offsets setpoint, odd offsets duty
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < N_ENTRIES; i++) begin
        lut_t[i] <= RST_LUT_T;
        lut_d[i] <= RST_LUT_D;
      end
    end else if (reg_wr_i && lut_hit) begin
      if (lut_off[0]) begin
        lut_d[lut_idx] <= reg_wdata_i; // [R2]
      end else begin
        lut_t[lut_idx] <= reg_wdata_i; // [R2]
      end
    end
  end

  // Ascending setpoints make a count equal to the active index
  always_comb begin
    up_cnt = 4'h0;
    hold_cnt = 4'h0;
    for (int i = 0; i < N_ENTRIES; i++) begin
      up_cnt = up_cnt + 4'(above(t_half, lut_t[i], 8'h00, half_res));
      hold_cnt = hold_cnt + 4'(above(t_half, lut_t[i], hyst, half_res)); // [R10]
    end
  end

  always_comb begin
    if (up_cnt > idx) begin
      next_idx = up_cnt;
    end else if (hold_cnt < idx) begin
      next_idx = hold_cnt; // [R10]
    end else begin
      next_idx = idx; // [R7]
    end
  end

  // Ramp direction
  always_comb begin
    if (!smooth_en || cur == target) begin
      next_state = RAMP_HOLD;
    end else if (cur < target) begin
      next_state = RAMP_UP;
    end else begin
      next_state = RAMP_DOWN;
    end
  end

  always_comb begin
    case (state)
      RAMP_UP: next_cur = sm_step ? cur + 8'h01 : cur; // [R5]
      RAMP_DOWN: next_cur = sm_step ? cur - 8'h01 : cur; // [R21]
      RAMP_HOLD: next_cur = smooth_en ? cur : target; // [R4]
      default: next_cur = target;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx <= 4'h0;
      cur <= 8'h00;
      state <= RAMP_HOLD;
      sm_cnt <= '0;
      crit <= 1'b0;
      out_duty <= 8'h00;
    end else begin
      idx <= next_idx;
      state <= next_state;
      cur <= next_cur;
      sm_cnt <= sm_step ? '0 : sm_cnt + 1'b1; // [R13]
      crit <= (t_int > crit_lim); // [R20]
      // Ramp keeps tracking underneath so release resumes from the value the ramp has reached
      out_duty <= crit ? full : next_cur; // [R11]
    end
  end

  // Read path, unmapped addresses read as zero
  always_comb begin
    next_rdata = 8'h00;
    if (lut_hit) begin
      next_rdata = lut_off[0] ? lut_d[lut_idx] : lut_t[lut_idx];
    end else begin
      case (reg_addr_i)
        A_TACH_LO: next_rdata = tach_cnt[7:0]; // [R16]
        A_TACH_HI: next_rdata = tach_cnt[15:8]; // [R16]
        A_ENH_CFG: next_rdata = 8'(cfg.hires) << B_HIRES;
        A_PWM_CFG: next_rdata = 8'(cfg.clk_sel) << B_CLKSEL;
        A_PWM_VAL: next_rdata = out_duty;
        A_PWM_FREQ: next_rdata = {3'b000, cfg.freq};
        A_HYST: next_rdata = hyst;
        A_CRIT: next_rdata = crit_lim;
        A_SMOOTH: next_rdata = {2'b00, smooth_en, 2'b00, sm_sel, half_res};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // Critical pin is open drain, active low
  assign critical_temp_output_o = crit;
  assign crit_pin_o = 1'b0;
  assign crit_pin_oe_o = crit;

  lfp_pwm_gen #(
    .LO_DIV(PWM_LO_DIV)
  ) u_pwm (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cfg_i(cfg),
    .duty_i(out_duty),
    .pwm_o(pwm_o),
    .pwm_pin_o(pwm_pin_o),
    .pwm_pin_oe_o(pwm_pin_oe_o)
  );

  lfp_tach_count #(
    .DIV(TACH_DIV)
  ) u_tach (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tach_i(tach_i),
    .count_o(tach_cnt)
  );
endmodule : lfp_fan_ctrl
`default_nettype wire

// File: lfp_fan_ctrl_sva.sv
// Port checker for the table-driven fan controller.
// Assumes a bind onto lfp_fan_ctrl from the bench top.
`timescale 1ns/1ns
`default_nettype none
module lfp_fan_ctrl_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Temperature and pins
  input wire logic [lfp_pkg::TEMP_W-1:0] remote_temp_i,
  input wire logic pwm_o,
  input wire logic pwm_pin_o,
  input wire logic pwm_pin_oe_o,
  input wire logic critical_temp_output_o,
  input wire logic crit_pin_o,
  input wire logic crit_pin_oe_o
);
  import lfp_pkg::*;
  logic [7:0] lim_q;
  // Shadow of the limit, so crit is judged without peeking inside
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lim_q <= RST_CRIT;
    end else if (reg_wr_i && reg_addr_i == A_CRIT) begin
      lim_q <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_PWM_PIN: assert property (pwm_pin_o == 1'b0 && pwm_pin_oe_o == !pwm_o)
    else $error("pwm pin not open drain of pwm level");
  AST_CRIT_PIN: assert property (crit_pin_o == 1'b0 && crit_pin_oe_o == critical_temp_output_o)
    else $error("crit pin does not follow crit level");
  AST_CRIT_SET: assert property ((remote_temp_i[10:3] > lim_q) |=> critical_temp_output_o)
    else $error("crit missing above limit");
  AST_CRIT_CLR: assert property ((remote_temp_i[10:3] <= lim_q) |=> !critical_temp_output_o)
    else $error("crit set at or below limit");
  AST_CRIT_FULL: assert property (critical_temp_output_o [*4] |-> !$fell(pwm_o))
    else $error("pwm not full on under crit");
  AST_RD_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  AST_RD_UNMAP: assert property (reg_rd_i && reg_addr_i == 8'h20 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_RD_LIMIT: assert property (reg_rd_i && reg_addr_i == A_CRIT |=> reg_rdata_o == $past(lim_q))
    else $error("limit readback wrong");
endmodule : lfp_fan_ctrl_sva
`default_nettype wire

// File: lfp_fan_model.sv
// Four-wire fan: pulled-up PWM input, open-collector tach output.
// Assumes the system clock as time base; tach starts high and holds its level while stopped.
`timescale 1ns/1ns
`default_nettype none
module lfp_fan_model #(
  parameter int HALF = 1110
) (
  // Clock
  input wire logic clk_i,
  // Pins
  input wire logic pwm_pin_i,
  input wire logic pwm_pin_oe_i,
  input wire logic run_i,
  output logic tach_o,
  // Observation
  input wire logic clr_i,
  output logic [15:0] on_cnt_o
);
  int ph;
  wire logic pin_lvl = pwm_pin_oe_i ? pwm_pin_i : 1'b1;
  initial begin
    tach_o = 1'b1;
    ph = 0;
    on_cnt_o = 16'h0000;
  end
  always @(posedge clk_i) begin
    on_cnt_o <= clr_i ? 16'h0000 : on_cnt_o + {15'h0000, pin_lvl};
    if (run_i) begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      if (ph == HALF - 1) begin
        tach_o <= !tach_o; // Two pulses per revolution
      end
    end
  end
endmodule : lfp_fan_model
`default_nettype wire

// File: tb.sv
// Self-checking bench for the fan controller, fan model on the pins.
// Assumes short divider parameters: 4 for the slow PWM clock, 8 for ramp base.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import lfp_pkg::*;
  logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, tach_i, run, clr;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, v, w;
  logic [TEMP_W-1:0] remote_temp_i;
  logic pwm_o, pwm_pin_o, pwm_pin_oe_o, critical_temp_output_o, crit_pin_o, crit_pin_oe_o;
  logic [15:0] on_cnt;
  int errors, check_count, cyc;
  lfp_fan_ctrl #(.PWM_LO_DIV(4), .SMOOTH_BASE_CYC(8), .N_ENTRIES(12)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .remote_temp_i(remote_temp_i), .tach_i(tach_i), .pwm_o(pwm_o), .pwm_pin_o(pwm_pin_o),
    .pwm_pin_oe_o(pwm_pin_oe_o), .critical_temp_output_o(critical_temp_output_o),
    .crit_pin_o(crit_pin_o), .crit_pin_oe_o(crit_pin_oe_o));
  lfp_fan_model #(.HALF(1110)) i_fan (.clk_i(clk_i), .pwm_pin_i(pwm_pin_o),
    .pwm_pin_oe_i(pwm_pin_oe_o), .run_i(run), .tach_o(tach_i), .clr_i(clr), .on_cnt_o(on_cnt));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  // Generous ceiling: the whole run needs under 20000 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      $display("[ERR] run time expected below 60000 seen 60000");
      wrap_up();
    end
  end
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [15:0] g);
    check_count++;
    if ($isunknown(g) || g < lo || g > hi) begin
      errors++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge clk_i);
    #1;
    reg_wr_i = 1'b0;
    // Idle edge so a following call never re-raises the strobe in the same step
    @(posedge clk_i);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge clk_i);
    #1;
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
    @(posedge clk_i);
    #1;
  endtask : rd
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a, v);
    chk8(nm, e, v);
  endtask : rchk
  // Index then output each take one cycle
  task automatic duty(input int t8, input logic [7:0] e);
    remote_temp_i = t8[TEMP_W-1:0];
    repeat (4) @(posedge clk_i);
    #1;
    rchk("duty", A_PWM_VAL, e);
  endtask : duty
  task automatic ramp(input int t8, input logic [7:0] e, input int lo, input int hi);
    int n;
    logic [7:0] p;
    remote_temp_i = t8[TEMP_W-1:0];
    rd(A_PWM_VAL, p);
    // Each read takes two cycles, so n counts cycles
    n = 2;
    while (p !== e && n < 1000) begin
      rd(A_PWM_VAL, v);
      if (v !== p) chk8("ramp step", (e > p) ? p + 8'h01 : p - 8'h01, v);
      p = v;
      n += 2;
    end
    chk_rng("ramp cycles", lo, hi, n[15:0]);
  endtask : ramp
  task automatic t_reset();
    rchk("freq", A_PWM_FREQ, 8'h08);
    rchk("hyst", A_HYST, 8'h04);
    rchk("limit", A_CRIT, 8'h55);
    rchk("setpoint", A_LUT_BASE, 8'hFF);
    rchk("unmapped", 8'h20, 8'h00);
    rchk("tach lo", A_TACH_LO, 8'hFF);
    rchk("tach hi", A_TACH_HI, 8'hFF);
    $display("test reset done");
  endtask : t_reset
  task automatic t_table();
    for (int k = 0; k < 12; k++) begin
      wr(A_LUT_BASE + 8'(2 * k), 8'(10 + 5 * k)); // Ascending table
      wr(A_LUT_BASE + 8'(2 * k + 1), 8'(2 * k + 1));
    end
    for (int k = 0; k < 12; k++) duty(8 * (12 + 5 * k), 8'(2 * k + 1));
    duty(8 * 5, 8'h00);
    duty(8 * 62, 8'd21);
    duty(8 * 58, 8'd21);
    duty(8 * 55, 8'd19);
    duty(8 * 60 + 4, 8'd19);
    duty(8 * 55, 8'd19);
    wr(A_SMOOTH, 8'h01);
    duty(8 * 60 + 3, 8'd19);
    duty(8 * 60 + 4, 8'd21);
    $display("test table done");
  endtask : t_table
  task automatic t_smooth();
    wr(A_SMOOTH, 8'h26);
    ramp(8 * 70, 8'd23, 8, 24);
    wr(A_SMOOTH, 8'h20);
    ramp(8 * 50, 8'd17, 320, 400);
    $display("test smooth done");
  endtask : t_smooth
  task automatic t_crit();
    duty(8 * 90, 8'h10);
    chk8("crit", 8'h01, {7'h00, critical_temp_output_o});
    wr(A_SMOOTH, 8'h00);
    wr(A_ENH_CFG, 8'h10);
    wr(A_PWM_CFG, 8'h00);
    wr(A_PWM_FREQ, 8'h08);
    rchk("hires full", A_PWM_VAL, 8'hFF);
    duty(8 * 85, 8'd23);
    chk8("crit", 8'h00, {7'h00, critical_temp_output_o});
    $display("test crit done");
  endtask : t_crit
  task automatic t_pwm();
    wr(A_ENH_CFG, 8'h00);
    wr(A_PWM_CFG, 8'h08);
    duty(8 * 22, 8'd7);
    repeat (128) @(posedge clk_i);
    #1;
    clr = 1'b1;
    @(posedge clk_i);
    #1;
    clr = 1'b0;
    // Ten whole periods of 16 ticks of 4 clocks
    repeat (640) @(posedge clk_i);
    #1;
    chk_rng("pwm on time", 280, 280, on_cnt);
    $display("test pwm done");
  endtask : t_pwm
  task automatic t_tach();
    run = 1'b1;
    repeat (11100) @(posedge clk_i);
    #1;
    rd(A_TACH_LO, v);
    rd(A_TACH_HI, w);
    chk_rng("tach count", 39, 41, {w, v});
    $display("fan rpm %0d", 5400000 / {w, v}); // Host speed figure
    $display("test tach done");
  endtask : t_tach
  initial begin
    errors = 0;
    check_count = 0;
    cyc = 0;
    rst_n_i = 1'b0;
    {reg_wr_i, reg_rd_i, run, clr} = 4'h0;
    {reg_addr_i, reg_wdata_i} = 16'h0000;
    remote_temp_i = '0;
    repeat (2) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    t_reset();
    t_table();
    t_smooth();
    t_crit();
    t_pwm();
    t_tach();
    wrap_up();
  end
endmodule : tb
bind lfp_fan_ctrl lfp_fan_ctrl_sva i_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .remote_temp_i(remote_temp_i),
  .pwm_o(pwm_o), .pwm_pin_o(pwm_pin_o), .pwm_pin_oe_o(pwm_pin_oe_o),
  .critical_temp_output_o(critical_temp_output_o), .crit_pin_o(crit_pin_o),
  .crit_pin_oe_o(crit_pin_oe_o));
`default_nettype wire
